// ### verilog/pwg_guard.v
// Purpose: write access guard for the parameter store
// Assumes: requests arrive one per cycle from logic on clk
// Notes: answers every request one cycle later with a grant bit
//
// Behaviour
// - Network reads are always granted; network writes are too, except to status and with bad codes or log-ins.
// - Local reads of any parameter are always granted.
// - With both codes zero, status is 0 and local writes are free.
// - Primary code only gives favourites and status 2 until logged in.
// - Master code only blocks writes, status 1, until logged in.
// - Both codes block by default, primary gives favourites, master all.
// - Equal primary and master codes give full access after log-in.
// - Code writes of 1..9999 set, 0 deletes, and read back -1 or 0.
// - Local code changes are taken only while no protection is active.
// - Tool code changes act at once, keypad ones on group exit.
// - Log-in writes of 1..9999 try to unlock, 0 logs out.
// - The log-in register reads -1 while logged in, else 0.
// - Ten wrong log-ins lock log-in until the power is cycled.
// - Ten minutes after log-in or the last granted local write the guard logs out.
// - Mains power-up re-arms protection and drops any log-in.
// - A reset to delivery state clears both codes.
`default_nettype none
`include "pwg_map.vh"

module pwg_guard #(
  parameter [39:0] IDLE_CYCLES =
    40'd60 * `PWG_IDLE_TIME_MIN * `PWG_CLK_HZ
) (
  input wire clk,
  input wire rst,
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_src,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire req_fav,
  input wire keypad_group_exit,
  input wire mains_on,
  input wire factory_reset,
  output reg rsp_valid,
  output reg rsp_grant,
  output reg [15:0] rsp_rdata,
  output reg [15:0] prot_status,
  output reg login_locked
);

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  // True for a value that sets a code or attempts a log-in
  function in_range;
    input [15:0] v;
    begin
      in_range = (v >= `PWG_CODE_MIN) && (v <= `PWG_CODE_MAX);
    end
  endfunction

  // Status shown for given codes and log-in level
  // Codes alone decide when nobody is logged in. A favourites log-in
  // must never show 2 once the master code is gone, for example after
  // a delivery reset, or local writes would stay restricted.
  function [15:0] status_of;
    input [15:0] pri;
    input [15:0] mas;
    input [1:0] lvl;
    begin
      if (lvl == `PWG_LVL_FULL) begin
        status_of = `PWG_ST_FULL;
      end else if (mas == `PWG_RST_CODE) begin
        // Without a master code a primary log-in already opens all
        if (pri == `PWG_RST_CODE || lvl == `PWG_LVL_FAV) begin
          status_of = `PWG_ST_FULL;
        end else begin
          status_of = `PWG_ST_FAV;
        end
      end else if (lvl == `PWG_LVL_FAV) begin
        // Master set: primary log-in reaches favourites only
        status_of = `PWG_ST_FAV;
      end else begin
        status_of = `PWG_ST_NONE;
      end
    end
  endfunction

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  reg [15:0] primary_code;
  reg [15:0] master_code;
  reg [15:0] pend_primary;
  reg [15:0] pend_master;
  reg pend_primary_valid;
  reg pend_master_valid;
  reg [1:0] level;
  reg [3:0] fail_count;

  reg [15:0] next_primary;
  reg [15:0] next_master;
  reg [15:0] next_pend_primary;
  reg [15:0] next_pend_master;
  reg next_pend_primary_valid;
  reg next_pend_master_valid;
  reg [1:0] next_level;
  reg [3:0] next_fail_count;
  reg next_grant;
  reg [15:0] next_rdata;
  reg timer_reload;
  reg timer_stop;

  wire idle_expire;
  wire [15:0] cur_status;
  wire is_local;
  wire hit_primary;
  wire hit_master;
  wire hit_login;
  wire hit_status;
  wire locked_now;

  // ----------------------------------------------------------
  // Decode of the incoming request
  // ----------------------------------------------------------
  assign cur_status = status_of(primary_code, master_code, level);
  assign is_local = (req_src != `PWG_SRC_NET);
  assign hit_primary = (req_addr == `PWG_OFS_PRIMARY);
  assign hit_master = (req_addr == `PWG_OFS_MASTER);
  assign hit_login = (req_addr == `PWG_OFS_LOGIN);
  assign hit_status = (req_addr == `PWG_OFS_STATUS);
  assign locked_now = (fail_count >= `PWG_FAIL_LIMIT);

  // ----------------------------------------------------------
  // Read data of the guard registers
  // ----------------------------------------------------------
  // code register reads show only whether a code is set, never the code
  always @* begin
    next_rdata = `PWG_RD_CLEAR;
    if (hit_primary && primary_code != `PWG_RST_CODE) begin
      next_rdata = `PWG_RD_SET;
    end else if (hit_master && master_code != `PWG_RST_CODE) begin
      next_rdata = `PWG_RD_SET;
    end else if (hit_login && level != `PWG_LVL_NONE) begin
      next_rdata = `PWG_RD_SET;
    end else if (hit_status) begin
      next_rdata = cur_status;
    end
  end

  // ----------------------------------------------------------
  // Request handling and next state
  // ----------------------------------------------------------
  always @* begin
    next_primary = primary_code;
    next_master = master_code;
    next_pend_primary = pend_primary;
    next_pend_master = pend_master;
    next_pend_primary_valid = pend_primary_valid;
    next_pend_master_valid = pend_master_valid;
    next_level = level;
    next_fail_count = fail_count;
    next_grant = 1'b0;
    timer_reload = 1'b0;
    timer_stop = 1'b0;

    // keypad codes apply on group exit
    if (keypad_group_exit) begin
      if (pend_primary_valid) begin
        next_primary = pend_primary;
      end
      if (pend_master_valid) begin
        next_master = pend_master;
      end
      next_pend_primary_valid = 1'b0;
      next_pend_master_valid = 1'b0;
    end

    if (req_valid && !req_write) begin
      next_grant = 1'b1;
    end else if (req_valid && (hit_primary || hit_master)) begin
      // local code change needs no active protection
      if (!is_local || cur_status == `PWG_ST_FULL) begin
        // only 0 or 1..9999 are taken
        if (in_range(req_wdata) || req_wdata == `PWG_RST_CODE) begin
          next_grant = 1'b1;
          if (req_src == `PWG_SRC_KEYPAD) begin
            if (hit_primary) begin
              next_pend_primary = req_wdata;
              next_pend_primary_valid = 1'b1;
            end else begin
              next_pend_master = req_wdata;
              next_pend_master_valid = 1'b1;
            end
          end else if (hit_primary) begin
            // tool and network act at once
            next_primary = req_wdata;
          end else begin
            next_master = req_wdata;
          end
          if (is_local) begin
            timer_reload = level != `PWG_LVL_NONE;
          end
        end
      end
    end else if (req_valid && hit_login) begin
      next_grant = 1'b1;
      if (req_wdata == `PWG_RST_CODE) begin
        next_level = `PWG_LVL_NONE;
        timer_stop = 1'b1;
      end else if (!in_range(req_wdata) || locked_now) begin
        // locked or out of range: refused
        next_grant = 1'b0;
      end else if (master_code != `PWG_RST_CODE &&
                   req_wdata == master_code) begin
        next_level = `PWG_LVL_FULL;
        timer_reload = 1'b1;
      end else if (primary_code != `PWG_RST_CODE &&
                   req_wdata == primary_code) begin
        if (master_code == `PWG_RST_CODE) begin
          next_level = `PWG_LVL_FULL;
        end else begin
          next_level = `PWG_LVL_FAV;
        end
        timer_reload = 1'b1;
      end else begin
        next_fail_count = fail_count + 4'h1;
        next_grant = 1'b0;
      end
    end else if (req_valid && hit_status) begin
      // Status is read only
      next_grant = 1'b0;
    end else if (req_valid) begin
      if (!is_local) begin
        next_grant = 1'b1;
      end else if (cur_status == `PWG_ST_FULL) begin
        next_grant = 1'b1;
      end else if (cur_status == `PWG_ST_FAV) begin
        next_grant = req_fav;
      end else begin
        next_grant = 1'b0;
      end
      if (is_local && next_grant && level != `PWG_LVL_NONE) begin
        timer_reload = 1'b1;
      end
    end

    if (idle_expire && !timer_reload) begin
      next_level = `PWG_LVL_NONE;
    end

    if (factory_reset) begin
      next_primary = `PWG_RST_CODE;
      next_master = `PWG_RST_CODE;
      next_pend_primary_valid = 1'b0;
      next_pend_master_valid = 1'b0;
    end

    // mains power-up re-arms and drops lock-out
    if (mains_on) begin
      next_level = `PWG_LVL_NONE;
      next_fail_count = 4'h0;
      timer_stop = 1'b1;
      timer_reload = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  // Codes survive mains_on; only rst, delivery reset or a code write of 0 clears them
  always @(posedge clk) begin
    if (rst) begin
      primary_code <= `PWG_RST_CODE;
      master_code <= `PWG_RST_CODE;
      pend_primary <= `PWG_RST_CODE;
      pend_master <= `PWG_RST_CODE;
      pend_primary_valid <= 1'b0;
      pend_master_valid <= 1'b0;
      level <= `PWG_LVL_NONE;
      fail_count <= 4'h0;
    end else begin
      primary_code <= next_primary;
      master_code <= next_master;
      pend_primary <= next_pend_primary;
      pend_master <= next_pend_master;
      pend_primary_valid <= next_pend_primary_valid;
      pend_master_valid <= next_pend_master_valid;
      level <= next_level;
      fail_count <= next_fail_count;
    end
  end

  // ----------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------
  // Status tracks the state of the next cycle so it matches reads
  always @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_grant <= 1'b0;
      rsp_rdata <= 16'h0000;
      prot_status <= `PWG_ST_FULL;
      login_locked <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      rsp_grant <= req_valid & next_grant;
      rsp_rdata <= (req_valid && !req_write) ? next_rdata : 16'h0000;
      prot_status <= status_of(next_primary, next_master, next_level);
      login_locked <= (next_fail_count >= `PWG_FAIL_LIMIT);
    end
  end

  // ----------------------------------------------------------
  // Idle interval
  // ----------------------------------------------------------
  // cycle counter for the idle time
  pwg_idle_timer #(
    .CYCLES(IDLE_CYCLES)
  ) u_idle (
    .clk(clk),
    .rst(rst),
    .reload(timer_reload),
    .stop(timer_stop),
    .expire(idle_expire)
  );

endmodule // pwg_guard
`default_nettype wire

// ### verilog/pwg_map.vh
// Purpose: constants of the parameter write access guard
// Assumes: included by the guard, its monitor and the bench
// Notes: definitions only, no logic
`ifndef PWG_MAP_VH
`define PWG_MAP_VH

// ----------------------------------------------------------
// Parameter indices of the guard registers
// ----------------------------------------------------------
`define PWG_OFS_PRIMARY 16'h203d
`define PWG_OFS_MASTER 16'h203e
`define PWG_OFS_LOGIN 16'h203f
`define PWG_OFS_STATUS 16'h2040

// ----------------------------------------------------------
// Reset values and read-back values
// ----------------------------------------------------------
`define PWG_RST_CODE 16'h0000
`define PWG_RD_SET 16'hffff
`define PWG_RD_CLEAR 16'h0000
`define PWG_CODE_MIN 16'h0001
`define PWG_CODE_MAX 16'h270f

// ----------------------------------------------------------
// Protection status values
// ----------------------------------------------------------
`define PWG_ST_FULL 16'h0000
`define PWG_ST_NONE 16'h0001
`define PWG_ST_FAV 16'h0002

// ----------------------------------------------------------
// Requester sources and log-in levels
// ----------------------------------------------------------
`define PWG_SRC_NET 2'h0
`define PWG_SRC_TOOL 2'h1
`define PWG_SRC_KEYPAD 2'h2
`define PWG_LVL_NONE 2'h0
`define PWG_LVL_FAV 2'h1
`define PWG_LVL_FULL 2'h2

// ----------------------------------------------------------
// Timing and limits
// ----------------------------------------------------------
`define PWG_FAIL_LIMIT 4'ha
`define PWG_IDLE_TIME_MIN 10
`define PWG_CLK_HZ 40000000

`endif

// ### verilog/pwg_idle_timer.v
// Purpose: idle interval counter of the write access guard
// Assumes: single clock, synchronous active high reset
// Notes: counts down from CYCLES while armed, pulses once at end
`default_nettype none

module pwg_idle_timer #(
  parameter [39:0] CYCLES = 40'd24000000000
) (
  input wire clk,
  input wire rst,
  input wire reload,
  input wire stop,
  output reg expire
);

  reg [39:0] count;
  reg armed;

  // ----------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------
  // Reload wins over stop so a write in the same cycle keeps access
  always @(posedge clk) begin
    if (rst) begin
      count <= 40'h0;
      armed <= 1'b0;
      expire <= 1'b0;
    end else if (reload) begin
      count <= CYCLES;
      armed <= 1'b1;
      expire <= 1'b0;
    end else if (stop) begin
      armed <= 1'b0;
      expire <= 1'b0;
    end else if (armed && count <= 40'h1) begin
      armed <= 1'b0;
      expire <= 1'b1;
    end else begin
      if (armed) begin
        count <= count - 40'h1;
      end
      expire <= 1'b0;
    end
  end

endmodule // pwg_idle_timer
`default_nettype wire

// ### sim/pwg_host.sv
// Purpose: local requester model facing the write access guard
// Assumes: drives on the falling clock edge, one request per call
// Notes: idle address, data and favourite lines carry the inverse of the last value
`default_nettype none
module pwg_host (
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic [1:0] req_src,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  output logic req_fav,
  input wire logic rsp_valid,
  input wire logic rsp_grant,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_src = 2'h1;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    req_fav = 1'b0;
  end
  // One cycle request; answer is read where it stands, one edge later
  task automatic send(input logic w, input logic [1:0] s,
    input logic [15:0] a, input logic [15:0] d, input logic f,
    output logic g, output logic [15:0] q);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_src = s;
    req_addr = a;
    req_wdata = d;
    req_fav = f;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr = ~a; // Stale lines must not look like a request
    req_wdata = ~d;
    req_fav = ~f;
    g = rsp_valid ? rsp_grant : 1'bx; // Missing answer never matches
    q = rsp_rdata;
  endtask
endmodule // pwg_host
`default_nettype wire

// ### sim/pwg_guard_monitor.sv
// Purpose: port level checker of the write access guard
// Assumes: single clock, synchronous active high reset
// Notes: judges grants against the status seen at the request edge
`default_nettype none
`include "pwg_map.vh"
module pwg_guard_monitor #(
  parameter logic [39:0] IDLE_CYCLES = 40'd50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_src,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_fav,
  input wire logic mains_on,
  input wire logic factory_reset,
  input wire logic rsp_valid,
  input wire logic rsp_grant,
  input wire logic [15:0] prot_status,
  input wire logic login_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------
  // Request classes
  // ---------------------------------------------------------
  wire logic lw = req_valid && req_write && req_src != `PWG_SRC_NET;
  wire logic ord = req_addr < `PWG_OFS_PRIMARY ||
    req_addr > `PWG_OFS_STATUS;
  wire logic cw = lw && (req_addr == `PWG_OFS_PRIMARY ||
    req_addr == `PWG_OFS_MASTER);
  wire logic lg = lw && req_addr == `PWG_OFS_LOGIN && req_wdata != 0;
  chk_answer_once: assert property (req_valid |=> rsp_valid)
    else $error("request without answer");
  chk_no_spurious: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  chk_net_grant: assert property (req_valid &&
    req_src == `PWG_SRC_NET && req_addr != `PWG_OFS_STATUS |=> rsp_grant)
    else $error("network request refused");
  chk_read_grant: assert property (req_valid && !req_write |=>
    rsp_grant) else $error("read refused");
  chk_block_all: assert property (lw && ord &&
    prot_status == `PWG_ST_NONE |=> !rsp_grant)
    else $error("write taken under no access");
  chk_fav_only: assert property (lw && ord &&
    prot_status == `PWG_ST_FAV |=> rsp_grant == $past(req_fav))
    else $error("favourites rule broken");
  chk_code_locked: assert property (cw &&
    prot_status != `PWG_ST_FULL |=> !rsp_grant)
    else $error("code changed under protection");
  chk_code_range: assert property (cw &&
    req_wdata > `PWG_CODE_MAX |=> !rsp_grant)
    else $error("code out of range taken");
  chk_lock_login: assert property (lg && login_locked |=>
    !rsp_grant) else $error("log-in taken while locked");
  chk_mains_clear: assert property (mains_on |->
    ##[1:2] !login_locked) else $error("lock-out kept over mains");
  chk_factory_open: assert property (factory_reset |->
    ##[1:2] prot_status == `PWG_ST_FULL) else $error("codes kept");
  cover property (lw && ord && prot_status == `PWG_ST_FAV && req_fav);
  cover property (lg && login_locked);
  cover property (cw && prot_status == `PWG_ST_FULL);
endmodule // pwg_guard_monitor
bind pwg_guard pwg_guard_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
  .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata),
  .req_fav(req_fav), .mains_on(mains_on), .factory_reset(factory_reset),
  .rsp_valid(rsp_valid), .rsp_grant(rsp_grant),
  .prot_status(prot_status), .login_locked(login_locked));
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench of the write access guard
// Assumes: short idle interval of 50 cycles
// Notes: one task per scenario, inputs change on the falling edge
`default_nettype none
`include "pwg_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PRI = `PWG_OFS_PRIMARY;
  localparam logic [15:0] MAS = `PWG_OFS_MASTER;
  localparam logic [15:0] LOG = `PWG_OFS_LOGIN;
  localparam logic [15:0] ORD = 16'h1000; // Some ordinary parameter
  localparam logic [1:0] T = `PWG_SRC_TOOL;
  localparam logic [1:0] K = `PWG_SRC_KEYPAD;
  localparam logic [15:0] C1 = 16'h04d2; // Primary code 1234
  localparam logic [15:0] C2 = 16'h1e61; // Master code 7777
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] ev = 3'h0; // Exit, mains, factory pulses
  logic rv, rw, fv, sv, sg, lk, g;
  logic [1:0] rs;
  logic [15:0] ra, rd_, sd, st, q;
  int n_errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  pwg_guard #(.IDLE_CYCLES(40'd50)) u_dut (.clk(clk), .rst(rst),
    .req_valid(rv), .req_write(rw), .req_src(rs), .req_addr(ra),
    .req_wdata(rd_), .req_fav(fv), .keypad_group_exit(ev[0]),
    .mains_on(ev[1]), .factory_reset(ev[2]), .rsp_valid(sv),
    .rsp_grant(sg), .rsp_rdata(sd), .prot_status(st),
    .login_locked(lk));
  pwg_host u_host (.clk(clk), .req_valid(rv), .req_write(rw),
    .req_src(rs), .req_addr(ra), .req_wdata(rd_), .req_fav(fv),
    .rsp_valid(sv), .rsp_grant(sg), .rsp_rdata(sd));
  // ---------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task req(input logic w, input logic [1:0] s, input logic [15:0] a,
    input logic [15:0] d, input logic f, input logic eg);
    u_host.send(w, s, a, d, f, g, q);
    chk({15'h0000, g}, {15'h0000, eg});
  endtask
  task rdc(input logic [15:0] a, input logic [15:0] e);
    req(1'b0, T, a, 16'h0000, 1'b0, 1'b1);
    chk(q, e);
  endtask
  // Status is a level, looked at one cycle after the pulse lands
  task pulse(input logic [2:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 3'h0;
    @(negedge clk);
  endtask
  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task t_open;
    chk(st, `PWG_ST_FULL);
    rdc(PRI, `PWG_RD_CLEAR);
    rdc(LOG, `PWG_RD_CLEAR);
    req(1'b1, K, ORD, 16'h0005, 1'b0, 1'b1);
  endtask
  task t_primary;
    req(1'b1, T, PRI, C1, 1'b0, 1'b1);
    rdc(PRI, `PWG_RD_SET);
    chk(st, `PWG_ST_FAV);
    req(1'b1, T, ORD, 16'h0006, 1'b0, 1'b0);
    req(1'b1, K, ORD, 16'h0006, 1'b1, 1'b1);
    req(1'b0, K, ORD, 16'h0000, 1'b0, 1'b1);
    req(1'b1, `PWG_SRC_NET, ORD, 16'h0007, 1'b0, 1'b1);
    req(1'b1, T, LOG, C1 + 16'h0001, 1'b0, 1'b0);
    req(1'b1, T, LOG, C1, 1'b0, 1'b1);
    chk(st, `PWG_ST_FULL);
    rdc(LOG, `PWG_RD_SET);
  endtask
  // Write midway restarts the interval, so the late check is still open
  task t_idle;
    repeat (40) @(negedge clk);
    req(1'b1, T, ORD, 16'h0008, 1'b0, 1'b1);
    repeat (40) @(negedge clk);
    chk(st, `PWG_ST_FULL);
    repeat (20) @(negedge clk);
    chk(st, `PWG_ST_FAV);
    rdc(LOG, `PWG_RD_CLEAR);
  endtask
  task t_master;
    req(1'b1, T, LOG, C1, 1'b0, 1'b1);
    req(1'b1, T, MAS, 16'h2710, 1'b0, 1'b0);
    req(1'b1, T, `PWG_OFS_STATUS, 16'h0000, 1'b0, 1'b0);
    req(1'b1, T, MAS, C2, 1'b0, 1'b1);
    rdc(MAS, `PWG_RD_SET);
    req(1'b1, T, LOG, 16'h0000, 1'b0, 1'b1);
    chk(st, `PWG_ST_NONE);
    req(1'b1, T, PRI, 16'h0001, 1'b0, 1'b0);
    req(1'b1, K, ORD, 16'h0009, 1'b1, 1'b0);
    req(1'b1, T, LOG, C1, 1'b0, 1'b1);
    chk(st, `PWG_ST_FAV);
    req(1'b1, T, LOG, C2, 1'b0, 1'b1);
    chk(st, `PWG_ST_FULL);
  endtask
  task t_keypad;
    req(1'b1, K, PRI, 16'h0000, 1'b0, 1'b1);
    rdc(PRI, `PWG_RD_SET);
    pulse(3'h1);
    rdc(PRI, `PWG_RD_CLEAR);
    req(1'b1, T, LOG, 16'h0000, 1'b0, 1'b1);
    chk(st, `PWG_ST_NONE);
  endtask
  task t_lock;
    req(1'b1, T, LOG, C2, 1'b0, 1'b1);
    pulse(3'h2);
    chk(st, `PWG_ST_NONE);
    rdc(LOG, `PWG_RD_CLEAR);
    repeat (10) req(1'b1, K, LOG, 16'h0001, 1'b0, 1'b0);
    chk({15'h0000, lk}, 16'h0001);
    req(1'b1, T, LOG, C2, 1'b0, 1'b0);
    pulse(3'h2);
    chk({15'h0000, lk}, 16'h0000);
    req(1'b1, T, LOG, C2, 1'b0, 1'b1);
  endtask
  task t_same;
    pulse(3'h4);
    chk(st, `PWG_ST_FULL);
    rdc(MAS, `PWG_RD_CLEAR);
    req(1'b1, T, PRI, 16'h0007, 1'b0, 1'b1);
    req(1'b1, T, MAS, 16'h0007, 1'b0, 1'b1);
    req(1'b1, T, LOG, 16'h0000, 1'b0, 1'b1);
    chk(st, `PWG_ST_NONE);
    req(1'b1, T, LOG, 16'h0007, 1'b0, 1'b1);
    chk(st, `PWG_ST_FULL);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_open();
    t_primary();
    t_idle();
    t_master();
    t_keypad();
    t_lock();
    t_same();
    wrap_up();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
